// File: epoc_ctrl.sv
// Operation
// (RULE1) Control register reads zero normally; reset clears all power and latch bits
// (RULE2) Array power bit set only when bus latch already set beforehand
// (RULE3) Clearing bus latch also clears array power bit in same update
// (RULE4) Write setting both bits sets latch only, power stays clear
// (RULE5) With latch set, next array write is latched; array reads blocked
// (RULE6) Option power bit is read/write, routes power to option cells
// (RULE7) Software: latch, write data, power for program time, clear both
// (RULE8) Option byte is nonvolatile, unchanged by reset, erased value zero
// (RULE9) Pulldown-inhibit bit one blocks software pulldown control on ports
// (RULE10) Stop delay bit selects 4064 or 16 bus cycles
// (RULE11) Oscillator shunt bit connects internal shunt resistor when one
// (RULE12) Stop conversion one: STOP enters halt, oscillator and timer run
// (RULE13) Stop conversion zero: STOP halts oscillator, clocks and watchdog
// (RULE14) Low-supply reset bit enables low-supply reset function
// (RULE15) Port interrupt bit lets port A low pins raise interrupts
// (RULE16) Sensitivity bit one adds level triggering to edge triggering
// (RULE17) Watchdog enable bit turns watchdog on
// (RULE18) Security bit set makes array and option reads undefined off user mode
// (RULE19) Software: write option data, apply voltage, pulse option power
// (RULE20) Software: write security bit, apply voltage, pulse option power
// (RULE21) Space is 6144 array bytes plus 16-byte vector and option region
// (RULE22) Software should reset before verifying after option programming
// (RULE23) Program times are timed by software or an external counter
`timescale 1ns/10ps
module epoc_ctrl (
  input  wire logic        hclk,            // Bus clock
  input  wire logic        hresetn,         // Async reset, active low
  input  wire logic        hsel,            // Slave select
  input  wire logic [15:0] haddr,           // Byte address
  input  wire logic [1:0]  htrans,          // Transfer type
  input  wire logic        hwrite,          // Write strobe
  input  wire logic [2:0]  hsize,           // Transfer size
  input  wire logic [31:0] hwdata,          // Write data
  input  wire logic        hready,          // Bus ready in
  input  wire logic        stop_req,        // STOP executed, same domain
  input  wire logic        stop_wake,       // Wake from stop, same domain
  input  wire logic        pulldown_sw,     // Software pulldown request
  input  wire logic [3:0]  port_a_low_pins, // Async port pins
  input  wire logic        irq_pin,         // Async interrupt pin, raw
  output logic [31:0]      hrdata,          // Read data
  output logic             hreadyout,       // Always ready
  output logic             hresp,           // Always OKAY
  output logic             array_program_power,  // Power to array
  output logic             option_program_power, // Power to option cells
  output logic             latch_we,        // Latched array write pulse
  output logic [15:0]      latch_addr,      // Latched array address
  output logic [7:0]       latch_data,      // Latched array data
  output logic             pulldown_en,     // Pulldowns enabled
  output logic             osc_shunt_select,// Shunt resistor connected
  output logic             low_supply_reset_enable, // Low-supply reset on
  output logic             watchdog_enable, // Watchdog on
  output logic             osc_run,         // Oscillator running
  output logic             cpu_clk_en,      // CPU clock enabled
  output logic             timer_clk_en,    // Timer clock enabled
  output logic             watchdog_run,    // Watchdog clocked
  output logic             ext_irq          // External interrupt request
);

  // Registers
  logic [7:0]  ctrl_reg;
  logic [7:0]  opt_reg;          // Nonvolatile cells, no reset
  logic        sec_reg;          // Nonvolatile cell, no reset
  logic [7:0]  opt_stage_reg;    // Option data waiting for power
  logic        sec_stage_reg;
  logic        user_mode_reg;
  logic        wr_ph_reg;
  logic [15:0] addr_ph_reg;
  logic        rd_ph_reg;
  logic [1:0]  pa_s1_reg [4];
  logic [3:0]  pa_s2_reg, pa_d_reg;
  logic        irq_s1_reg, irq_s2_reg, irq_d_reg;
  logic [11:0] dly_reg;
  typedef enum {RUN, HALT, STOPPED, RESTART} epoc_pwr_t;
  epoc_pwr_t   pwr_reg;
  logic [7:0]  ctrl_next;
  epoc_pkg::epoc_opt_t opt;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic        in_array, in_vec;

  assign opt = epoc_pkg::epoc_opt_t'(opt_reg);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg   <= 1'b0;
      rd_ph_reg   <= 1'b0;
      addr_ph_reg <= 16'h0000;
    end else if (hready) begin
      wr_ph_reg   <= hsel & htrans[1] & hwrite;
      rd_ph_reg   <= hsel & htrans[1] & ~hwrite;
      addr_ph_reg <= haddr;
    end
  end

  // Byte lane of the addressed location
  always_comb begin
    unique case (addr_ph_reg[1:0])
      2'b00: wbyte = hwdata[7:0];
      2'b01: wbyte = hwdata[15:8];
      2'b10: wbyte = hwdata[23:16];
      default: wbyte = hwdata[31:24];
    endcase
  end

  assign in_array = addr_ph_reg >= epoc_pkg::ARRAY_BASE &&
                    addr_ph_reg <= epoc_pkg::ARRAY_LAST; // see (RULE21)
  assign in_vec   = addr_ph_reg >= epoc_pkg::VEC_BASE &&
                    addr_ph_reg <= epoc_pkg::VEC_LAST;   // see (RULE21)

  // Interlock between latch and array power
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ph_reg && addr_ph_reg == epoc_pkg::CTRL_ADDR) begin
      ctrl_next = 8'h00;
      ctrl_next[epoc_pkg::BL_BIT]  = wbyte[epoc_pkg::BL_BIT];
      ctrl_next[epoc_pkg::OPP_BIT] = wbyte[epoc_pkg::OPP_BIT]; // see (RULE6)
      // Latch must already be set; same-write attempt leaves power off
      ctrl_next[epoc_pkg::APP_BIT] = wbyte[epoc_pkg::APP_BIT] &
        ctrl_reg[epoc_pkg::BL_BIT] & wbyte[epoc_pkg::BL_BIT]; // see (RULE2) (RULE4) (RULE3)
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_reg <= epoc_pkg::CTRL_RESET; // see (RULE1)
    else ctrl_reg <= ctrl_next;
  end

  // User-mode flag, software controlled, cleared means non-user
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) user_mode_reg <= 1'b1;
    else if (wr_ph_reg && addr_ph_reg == epoc_pkg::MODE_ADDR)
      user_mode_reg <= wbyte[0];
  end

  // Array latch: next array write while latched is captured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_we   <= 1'b0;
      latch_addr <= 16'h0000;
      latch_data <= 8'h00;
    end else begin
      latch_we <= 1'b0;
      if (wr_ph_reg && in_array && ctrl_reg[epoc_pkg::BL_BIT]) begin
        latch_we   <= 1'b1;                              // see (RULE5)
        latch_addr <= addr_ph_reg;
        latch_data <= wbyte;
      end
    end
  end

  // Staging of option and security data written before power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_stage_reg <= epoc_pkg::OPT_ERASED;
      sec_stage_reg <= 1'b0;
    end else if (wr_ph_reg && addr_ph_reg == epoc_pkg::OPT_ADDR) begin
      opt_stage_reg <= wbyte;                            // see (RULE19)
    end else if (wr_ph_reg && addr_ph_reg == epoc_pkg::SEC_ADDR) begin
      sec_stage_reg <= wbyte[epoc_pkg::SEC_BIT];         // see (RULE20)
    end
  end

  // Nonvolatile cells: only programming power changes them, never reset.
  // EPROM can only be programmed toward one, so bits OR in.
  always_ff @(posedge hclk) begin
    if (ctrl_reg[epoc_pkg::OPP_BIT]) begin
      opt_reg <= opt_reg | opt_stage_reg;                // see (RULE8)
      sec_reg <= sec_reg | sec_stage_reg;                // see (RULE18)
    end
  end

  // Read mux on the address phase, so data stand for the whole data phase.
  // Blocked data are undefined, shown as zero; array content not held here.
  always_comb begin
    rd_byte = 8'h00;
    if (haddr == epoc_pkg::CTRL_ADDR)
      rd_byte = ctrl_reg;                                // see (RULE1)
    else if (haddr == epoc_pkg::OPT_ADDR && !(sec_reg && !user_mode_reg))
      rd_byte = opt_reg;                                 // see (RULE18)
    else if (haddr == epoc_pkg::OPTW_ADDR)
      rd_byte = opt_stage_reg;
  end

  // Bus answer: zero wait states, OKAY; byte shown on every lane
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= {4{rd_byte}};                            // see (RULE5)
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Power outputs straight from the control register
  assign array_program_power  = ctrl_reg[epoc_pkg::APP_BIT];
  assign option_program_power = ctrl_reg[epoc_pkg::OPP_BIT];

  // Option decode to system controls, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulldown_en             <= 1'b0;
      osc_shunt_select        <= 1'b0;
      low_supply_reset_enable <= 1'b0;
      watchdog_enable         <= 1'b0;
    end else begin
      pulldown_en <= pulldown_sw & ~opt.pulldown_inhibit;      // see (RULE9)
      osc_shunt_select        <= opt.osc_shunt_select;         // see (RULE11)
      low_supply_reset_enable <= opt.low_supply_reset_enable;  // see (RULE14)
      watchdog_enable         <= opt.watchdog_enable;          // see (RULE17)
    end
  end

  // Pin synchronisers, two flops before any logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_s1_reg <= 1'b1;
      irq_s2_reg <= 1'b1;
      irq_d_reg  <= 1'b1;
      pa_s2_reg  <= 4'h0;
      pa_d_reg   <= 4'h0;
      for (int i = 0; i < 4; i++) pa_s1_reg[i] <= 2'b00;
    end else begin
      irq_s1_reg <= irq_pin;
      irq_s2_reg <= irq_s1_reg;
      irq_d_reg  <= irq_s2_reg;
      for (int i = 0; i < 4; i++) begin
        pa_s1_reg[i] <= {1'b0, port_a_low_pins[i]};
        pa_s2_reg[i] <= pa_s1_reg[i][0];
      end
      pa_d_reg <= pa_s2_reg;
    end
  end

  // Pin edge always triggers, port edge only with its option; level only with sensitivity option
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ext_irq <= 1'b0;
    else ext_irq <= (irq_d_reg & ~irq_s2_reg)
      | (opt.level_sense & ~irq_s2_reg)                  // see (RULE16)
      | (opt.port_interrupt_enable &                     // see (RULE15)
         (|(pa_s2_reg & ~pa_d_reg) |
          (opt.level_sense & |pa_s2_reg)));              // see (RULE16)
  end

  // Stop, halt and restart sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_reg <= RUN;
      dly_reg <= 12'h000;
    end else begin
      unique case (pwr_reg)
        RUN: if (stop_req)
          pwr_reg <= opt.stop_conversion ? HALT : STOPPED; // see (RULE12) (RULE13)
        HALT: if (stop_wake) pwr_reg <= RUN;
        STOPPED: if (stop_wake) begin
          pwr_reg <= RESTART;
          dly_reg <= opt.long_stop_delay ? epoc_pkg::STOP_DLY_LONG
                                         : epoc_pkg::STOP_DLY_SHORT; // see (RULE10)
        end
        RESTART: begin
          dly_reg <= dly_reg - 12'h001;
          if (dly_reg == 12'h001) pwr_reg <= RUN;
        end
      endcase
    end
  end

  // Clock gating per state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_run      <= 1'b1;
      cpu_clk_en   <= 1'b1;
      timer_clk_en <= 1'b1;
      watchdog_run <= 1'b1;
    end else begin
      osc_run      <= pwr_reg != STOPPED;                // see (RULE13)
      cpu_clk_en   <= pwr_reg == RUN;                    // see (RULE12)
      timer_clk_en <= pwr_reg == RUN || pwr_reg == HALT; // see (RULE12)
      watchdog_run <= pwr_reg == RUN || pwr_reg == HALT; // see (RULE13)
    end
  end

  // Power bit never on with latch off
  a_power_needs_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_reg[epoc_pkg::APP_BIT] |-> ctrl_reg[epoc_pkg::BL_BIT]) // see (RULE3)
    else $error("array power on without latch");

  // Single write of both bits leaves power off
  a_dual_set_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ph_reg && addr_ph_reg == epoc_pkg::CTRL_ADDR &&
     !ctrl_reg[epoc_pkg::BL_BIT]) |=> !ctrl_reg[epoc_pkg::APP_BIT]) // see (RULE4)
    else $error("power set without prior latch");

  a_reset_clears: assert property (@(posedge hclk)
    !hresetn |-> ctrl_reg == 8'h00) // see (RULE1)
    else $error("control not cleared by reset");

  a_latch_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_ph_reg && in_array && ctrl_reg[epoc_pkg::BL_BIT]) |=>
      latch_we && latch_addr == $past(addr_ph_reg)) // see (RULE5)
    else $error("array write not latched");

  a_opt_power_out: assert property (@(posedge hclk) disable iff (!hresetn)
    option_program_power == ctrl_reg[epoc_pkg::OPP_BIT]) // see (RULE6)
    else $error("option power mismatch");

  sequence s_stop_entry;
    pwr_reg == RUN && stop_req && !opt.stop_conversion;
  endsequence
  a_stop_halts_osc: assert property (@(posedge hclk) disable iff (!hresetn)
    s_stop_entry |=> ##1 !osc_run && !watchdog_run) // see (RULE13)
    else $error("stop did not halt oscillator");

  a_halt_keeps_timer: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwr_reg == RUN && stop_req && opt.stop_conversion) |=>
      ##1 timer_clk_en && !cpu_clk_en) // see (RULE12)
    else $error("halt clock state wrong");

  a_short_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwr_reg == STOPPED && stop_wake && !opt.long_stop_delay) |=>
      (pwr_reg == RESTART) [*8] ##1 (pwr_reg == RESTART) [*8] ##1
      pwr_reg == RUN) // see (RULE10)
    else $error("short stop delay wrong");

  a_pulldown_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
    opt.pulldown_inhibit |=> !pulldown_en) // see (RULE9)
    else $error("pulldown not inhibited");

  // Halt leaves on the wake event alone
  a_halt_wakes: assert property (@(posedge hclk) disable iff (!hresetn)
    (pwr_reg == HALT && stop_wake) |=> pwr_reg == RUN) // see (RULE12)
    else $error("halt did not wake");

  // Decode outputs trail the cells by one edge; programmed cells switch their outputs on
  a_shunt_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(hresetn) && $past(opt.osc_shunt_select)) |->
      osc_shunt_select) // see (RULE11)
    else $error("shunt select not driven");

  a_lsr_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(hresetn) && $past(opt.low_supply_reset_enable)) |->
      low_supply_reset_enable) // see (RULE14)
    else $error("low supply reset not enabled");

  a_wdog_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(hresetn) && $past(opt.watchdog_enable)) |->
      watchdog_enable) // see (RULE17)
    else $error("watchdog not enabled");

  // Port pins stay silent while their option is off and the pin is idle
  a_port_irq_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!opt.port_interrupt_enable && irq_s2_reg && irq_d_reg) |=>
      !ext_irq) // see (RULE15)
    else $error("port pins raised interrupt");

  a_irq_falling: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_d_reg && !irq_s2_reg) |=> ext_irq) // see (RULE16)
    else $error("falling pin edge missed");

  // Array content never leaves the block
  a_array_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_ph_reg && in_array) |-> hrdata == 32'h0000_0000) // see (RULE5)
    else $error("array read returned data");

  // Secured option byte hidden outside user mode
  a_secure_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_ph_reg && addr_ph_reg == epoc_pkg::OPT_ADDR && sec_reg &&
     !user_mode_reg) |-> hrdata == 32'h0000_0000) // see (RULE18)
    else $error("secured option byte readable");

endmodule // epoc_ctrl

// File: epoc_pkg.sv
package epoc_pkg;

  // Byte addresses on the AHB-Lite register bus
  localparam logic [15:0] CTRL_ADDR     = 16'h1FE0;
  localparam logic [15:0] SEC_ADDR      = 16'h1FF0;
  localparam logic [15:0] OPT_ADDR      = 16'h1FF1;
  localparam logic [15:0] OPTW_ADDR     = 16'h1FF4;
  localparam logic [15:0] MODE_ADDR     = 16'h1FF8;
  localparam logic [15:0] ARRAY_BASE    = 16'h0700;
  localparam logic [15:0] ARRAY_LAST    = 16'h1EFF;
  localparam logic [15:0] VEC_BASE      = 16'h1FF0;
  localparam logic [15:0] VEC_LAST      = 16'h1FFF;

  // Control register fields
  localparam int          BL_BIT        = 2;
  localparam int          OPP_BIT       = 1;
  localparam int          APP_BIT       = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Option byte fields
  localparam int          OPT_PDI       = 7;
  localparam int          OPT_DLY       = 6;
  localparam int          OPT_OSC       = 5;
  localparam int          OPT_STC       = 4;
  localparam int          OPT_LSR       = 3;
  localparam int          OPT_PIE       = 2;
  localparam int          OPT_LVL       = 1;
  localparam int          OPT_WDE       = 0;
  localparam logic [7:0]  OPT_ERASED    = 8'h00;
  localparam int          SEC_BIT       = 7;

  // Stop restart delay in bus cycles
  localparam logic [11:0] STOP_DLY_LONG  = 12'hFE0;
  localparam logic [11:0] STOP_DLY_SHORT = 12'h010;

  // Option decode bundle
  typedef struct packed {
    logic pulldown_inhibit;
    logic long_stop_delay;
    logic osc_shunt_select;
    logic stop_conversion;
    logic low_supply_reset_enable;
    logic port_interrupt_enable;
    logic level_sense;
    logic watchdog_enable;
  } epoc_opt_t;

endpackage

// File: tb.sv
`timescale 1ns/10ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        stop_req;
  logic        stop_wake;
  logic        pulldown_sw;
  logic [3:0]  port_a_low_pins;
  logic        irq_pin;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        app;
  logic        opp;
  logic        latch_we;
  logic [15:0] latch_addr;
  logic [7:0]  latch_data;
  logic        pd_en;
  logic        osc_sh;
  logic        lsr_en;
  logic        wd_en;
  logic        osc_run;
  logic        cpu_en;
  logic        tmr_en;
  logic        wd_run;
  logic        ext_irq;
  logic [31:0] rd;
  logic [15:0] cap_addr;
  logic [7:0]  cap_data;
  int          we_count;
  int          bad_count;
  int          check_count;
  int          n;
  // Program time in cycles; arbitrary, external timing is not fixed
  localparam int PROG_CYCLES = 20;

  epoc_ctrl u_epoc_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .stop_req(stop_req), .stop_wake(stop_wake),
    .pulldown_sw(pulldown_sw), .port_a_low_pins(port_a_low_pins),
    .irq_pin(irq_pin), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .array_program_power(app),
    .option_program_power(opp), .latch_we(latch_we),
    .latch_addr(latch_addr), .latch_data(latch_data),
    .pulldown_en(pd_en), .osc_shunt_select(osc_sh),
    .low_supply_reset_enable(lsr_en), .watchdog_enable(wd_en),
    .osc_run(osc_run), .cpu_clk_en(cpu_en), .timer_clk_en(tmr_en),
    .watchdog_run(wd_run), .ext_irq(ext_irq));

  // Clock, 10 ns period
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Capture latched array writes; the pulse lasts one cycle only
  always @(posedge hclk) begin
    if (latch_we === 1'b1) begin
      we_count <= we_count + 1;
      cap_addr <= latch_addr;
      cap_data <= latch_data;
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Byte replicated on every lane, so the lane choice never matters
  task automatic ahb_write(logic [15:0] a, logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {4{d}};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic ahb_read(logic [15:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= 1'b0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  // Let write effects land, then sample away from the edge
  task automatic settle(int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask

  // Power pulse held for the program time, then all bits cleared
  task automatic power_pulse(logic [7:0] c);
    ahb_write(epoc_pkg::CTRL_ADDR, c);
    repeat (PROG_CYCLES) @(posedge hclk);
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h00);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs about 250 cycles; a hang is cut well beyond that
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 16'h0000; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; stop_req = 1'b0;
    stop_wake = 1'b0; pulldown_sw = 1'b1; port_a_low_pins = 4'h0;
    irq_pin = 1'b1; we_count = 0; bad_count = 0; check_count = 0;
    do_reset();
    // Reset state of the control register
    #1;
    check("app after reset", 32'h0, {31'h0, app});
    check("opp after reset", 32'h0, {31'h0, opp});
    ahb_read(epoc_pkg::CTRL_ADDR, rd);
    check("ctrl read", 32'h0, rd);
    $display("test reset done");
    // Power bit interlock against the bus latch
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h01);
    settle(2);
    check("app without latch", 32'h0, {31'h0, app});
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h05);
    settle(2);
    check("app same write", 32'h0, {31'h0, app});
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h05);
    settle(2);
    check("app latch set", 32'h1, {31'h0, app});
    ahb_read(epoc_pkg::CTRL_ADDR, rd);
    check("ctrl readback", 32'h05050505, rd);
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h01);
    settle(2);
    check("app latch cleared", 32'h0, {31'h0, app});
    $display("test interlock done");
    // Byte programming sequence with array latching
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h04);
    ahb_write(16'h0801, 8'h5A);
    settle(3);
    check("latch count", 32'h1, we_count);
    check("latch addr", 32'h0801, {16'h0, cap_addr});
    check("latch data", 32'h5A, {24'h0, cap_data});
    ahb_read(16'h0801, rd);
    check("array read latched", 32'h0, rd);
    power_pulse(8'h05);
    settle(2);
    check("app after clear", 32'h0, {31'h0, app});
    $display("test array program done");
    // Option byte without long restart delay or stop conversion
    ahb_write(epoc_pkg::OPT_ADDR, 8'hAF);
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h02);
    settle(1);
    check("opp set", 32'h1, {31'h0, opp});
    repeat (PROG_CYCLES) @(posedge hclk);
    ahb_write(epoc_pkg::CTRL_ADDR, 8'h00);
    settle(3);
    check("opp clear", 32'h0, {31'h0, opp});
    do_reset();
    settle(3);
    check("pulldown inhibited", 32'h0, {31'h0, pd_en});
    check("shunt on", 32'h1, {31'h0, osc_sh});
    check("low supply reset on", 32'h1, {31'h0, lsr_en});
    check("watchdog on", 32'h1, {31'h0, wd_en});
    check("opp after reset", 32'h0, {31'h0, opp});
    ahb_read(epoc_pkg::OPT_ADDR, rd);
    check("option kept", 32'hAFAFAFAF, rd);
    $display("test option done");
    // Full stop halts everything; restart takes the short delay
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
    settle(3);
    check("osc stopped", 32'h0, {31'h0, osc_run});
    check("timer stopped", 32'h0, {31'h0, tmr_en});
    check("watchdog stopped", 32'h0, {31'h0, wd_run});
    stop_wake <= 1'b1;
    @(posedge hclk);
    stop_wake <= 1'b0;
    n = 0;
    while (cpu_en !== 1'b1 && n < 5000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    // Restart count plus the registered clock enable
    check("restart cycles", {20'h0, epoc_pkg::STOP_DLY_SHORT} + 32'h1,
          n);
    // Add long delay and stop conversion; cells only gain ones
    ahb_write(epoc_pkg::OPT_ADDR, 8'h50);
    power_pulse(8'h02);
    do_reset();
    settle(3);
    ahb_read(epoc_pkg::OPT_ADDR, rd);
    check("option full", 32'hFFFFFFFF, rd);
    // STOP converted to halt keeps the oscillator and timer
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
    settle(4);
    check("cpu clock halted", 32'h0, {31'h0, cpu_en});
    check("osc runs", 32'h1, {31'h0, osc_run});
    check("timer runs", 32'h1, {31'h0, tmr_en});
    stop_wake <= 1'b1;
    @(posedge hclk);
    stop_wake <= 1'b0;
    n = 0;
    while (cpu_en !== 1'b1 && n < 5000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    check("cpu clock resumed", 32'h1, {31'h0, cpu_en});
    $display("test stop done");
    // External interrupts: port pins high level, pin low level
    port_a_low_pins <= 4'h1;
    settle(8);
    check("port irq", 32'h1, {31'h0, ext_irq});
    port_a_low_pins <= 4'h0;
    settle(8);
    irq_pin <= 1'b0;
    settle(8);
    check("pin low irq", 32'h1, {31'h0, ext_irq});
    irq_pin <= 1'b1;
    settle(8);
    $display("test interrupt done");
    // Unmapped place reads zero and ignores writes
    ahb_write(16'h0100, 8'hAA);
    ahb_read(16'h0100, rd);
    check("unmapped read", 32'h0, rd);
    // Security bit: user mode still reads, non-user mode does not
    ahb_write(epoc_pkg::SEC_ADDR, 8'h80);
    power_pulse(8'h02);
    ahb_read(epoc_pkg::OPT_ADDR, rd);
    check("user option read", 32'hFFFFFFFF, rd);
    ahb_write(epoc_pkg::MODE_ADDR, 8'h00);
    ahb_read(epoc_pkg::OPT_ADDR, rd);
    check("secured option read", 32'h0, rd);
    $display("test security done");
    stop_test();
  end
endmodule // tb
